// *** rtl/eag_defs.svh ***
// Purpose: constants of the effective address generator
// Assumes: included by its bare name from the design file
// Notes: definitions only
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH

// reset values
`define EAG_PC_RST 16'h0000
`define EAG_ADDR_RST 16'h0000
`define EAG_BYTE_RST 8'h00

// page zero high byte
`define EAG_ZERO_PAGE 8'h00

// program counter steps
`define EAG_STEP1 16'h0001
`define EAG_STEP2 16'h0002
`define EAG_STEP3 16'h0003

// single bit seed for bit masks
`define EAG_BIT_SEED 8'h01

`endif

// *** rtl/eag_pkg.sv ***
// Purpose: types of the effective address generator
// Assumes: nothing
// Notes: mode codes are the values driven on I_MODE
package eag_pkg;

	typedef enum logic [3:0] {
		implied_operand     = 4'h0,
		literal_operand     = 4'h1,
		page_zero_absolute  = 4'h2,
		full_absolute       = 4'h3,
		pointer_no_offset   = 4'h4,
		pointer_byte_offset = 4'h5,
		pointer_word_offset = 4'h6,
		pc_offset_branch    = 4'h7,
		bit_set_clear       = 4'h8,
		bit_test_branch     = 4'h9
	} eag_mode_type;

	typedef enum logic [2:0] {
		st_idle   = 3'h0,
		st_fetch1 = 3'h1,
		st_fetch2 = 3'h2,
		st_read   = 3'h3,
		st_write  = 3'h4,
		st_finish = 3'h5
	} eag_state_type;

endpackage

// *** rtl/eag_top.sv ***
// Purpose: operand_location and next program counter for the ten addressing modes
// Assumes: PC holds the opcode address when I_START is seen; memory answers by I_MEM_ACK
// Notes: one instruction at a time; I_START while busy is ignored
// Notes on behaviour
// - implied mode is one byte, no operand fetch, pc steps by one
// - literal mode operand at pc plus one, pc steps by two
// - page zero mode: address high zero, low is next byte, pc plus two
// - full absolute: high byte from first operand, low from second, three bytes
// - jumps in full absolute mode load any address into pc
// - pointer no offset: high zero, low is table pointer, one byte
// - pointer byte offset: pointer plus byte, carry is high byte, pc plus two
// - pointer word offset: low pointer plus second byte, high first plus carry
// - pc offset branch: pc plus two plus signed offset when condition holds
// - bit set clear: opcode bit, page zero byte modified, pc plus two
// - bit test branch: test page zero bit, branch pc plus three plus offset
// - tested bit copied to carry flag whether or not branch taken
// - pc is a 16 bit register holding next byte to fetch
`timescale 1ns/1ps
`include "eag_defs.svh"

module eag_top (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_CE,
	// decode stage
	input wire logic I_START,
	input wire logic [3:0] I_MODE,
	input wire logic [2:0] I_BIT_SEL,
	input wire logic I_BIT_POL,
	input wire logic I_COND,
	input wire logic I_JUMP,
	input wire logic [7:0] I_INDEX,
	// program counter load
	input wire logic I_PC_LOAD,
	input wire logic [15:0] I_PC_VALUE,
	// memory bus
	output logic O_MEM_REQ,
	output logic O_MEM_WE,
	output logic [15:0] O_MEM_ADDR,
	output logic [7:0] O_MEM_WDATA,
	input wire logic I_MEM_ACK,
	input wire logic [7:0] I_MEM_RDATA,
	// results
	output logic O_BUSY,
	output logic O_DONE,
	output logic O_TAKEN,
	output logic [15:0] O_PC,
	output logic [15:0] O_EA,
	output logic O_CARRY_WE,
	output logic O_CARRY
);

	eag_pkg::eag_state_type state;
	eag_pkg::eag_state_type next_state;
	eag_pkg::eag_mode_type mode;
	eag_pkg::eag_mode_type in_mode;

	logic [15:0] pc, mem_addr, next_addr, calc_ea, calc_pc;
	logic [7:0] mem_wdata, next_wdata, opnd1, opnd2, data_byte, index, bit_mask;
	logic [8:0] sum_byte, sum_word;
	logic [2:0] bit_sel;
	logic mem_we, next_we, bit_pol, cond, jump, calc_taken, test_bit;

	// illegal mode codes fall back to a one byte instruction
	always_comb begin
		unique case (I_MODE)
			4'h1: in_mode = eag_pkg::literal_operand;
			4'h2: in_mode = eag_pkg::page_zero_absolute;
			4'h3: in_mode = eag_pkg::full_absolute;
			4'h4: in_mode = eag_pkg::pointer_no_offset;
			4'h5: in_mode = eag_pkg::pointer_byte_offset;
			4'h6: in_mode = eag_pkg::pointer_word_offset;
			4'h7: in_mode = eag_pkg::pc_offset_branch;
			4'h8: in_mode = eag_pkg::bit_set_clear;
			4'h9: in_mode = eag_pkg::bit_test_branch;
			default: in_mode = eag_pkg::implied_operand;
		endcase
	end

	assign bit_mask = `EAG_BIT_SEED << bit_sel;
	assign test_bit = |(data_byte & bit_mask);

	// sequencing of operand fetches and page zero accesses
	always_comb begin
		next_state = state;
		next_addr = mem_addr;
		next_we = mem_we;
		next_wdata = mem_wdata;
		unique case (state)
			eag_pkg::st_idle: begin
				if (I_START && !I_PC_LOAD) begin
					unique case (in_mode)
						eag_pkg::implied_operand,
						eag_pkg::literal_operand,
						eag_pkg::pointer_no_offset: next_state = eag_pkg::st_finish;
						default: begin
							next_state = eag_pkg::st_fetch1;
							next_addr = pc + `EAG_STEP1;
						end
					endcase
				end
			end
			eag_pkg::st_fetch1: begin
				if (I_MEM_ACK) begin
					unique case (mode)
						eag_pkg::full_absolute,
						eag_pkg::pointer_word_offset,
						eag_pkg::bit_test_branch: begin
							next_state = eag_pkg::st_fetch2;
							next_addr = pc + `EAG_STEP2;
						end
						eag_pkg::bit_set_clear: begin
							next_state = eag_pkg::st_read;
							next_addr = {`EAG_ZERO_PAGE, I_MEM_RDATA};
						end
						default: next_state = eag_pkg::st_finish;
					endcase
				end
			end
			eag_pkg::st_fetch2: begin
				if (I_MEM_ACK) begin
					if (mode == eag_pkg::bit_test_branch) begin
						next_state = eag_pkg::st_read;
						next_addr = {`EAG_ZERO_PAGE, opnd1};
					end else begin
						next_state = eag_pkg::st_finish;
					end
				end
			end
			eag_pkg::st_read: begin
				if (I_MEM_ACK) begin
					if (mode == eag_pkg::bit_set_clear) begin
						next_state = eag_pkg::st_write;
						next_we = 1'b1;
						next_wdata = bit_pol ? (I_MEM_RDATA | bit_mask) : (I_MEM_RDATA & ~bit_mask);
					end else begin
						next_state = eag_pkg::st_finish;
					end
				end
			end
			eag_pkg::st_write: begin
				if (I_MEM_ACK) begin
					next_state = eag_pkg::st_finish;
					next_we = 1'b0;
				end
			end
			eag_pkg::st_finish: next_state = eag_pkg::st_idle;
			default: next_state = eag_pkg::st_idle;
		endcase
	end

	// carries kept only where the mode uses them
	assign sum_byte = {1'b0, index} + {1'b0, opnd1};
	assign sum_word = {1'b0, index} + {1'b0, opnd2};

	// address and next pc per mode
	always_comb begin
		calc_ea = `EAG_ADDR_RST;
		calc_pc = pc + `EAG_STEP1;
		calc_taken = 1'b0;
		unique case (mode)
			eag_pkg::implied_operand: calc_pc = pc + `EAG_STEP1;
			eag_pkg::literal_operand: begin
				calc_ea = pc + `EAG_STEP1;
				calc_pc = pc + `EAG_STEP2;
			end
			eag_pkg::page_zero_absolute: begin
				calc_ea = {`EAG_ZERO_PAGE, opnd1};
				calc_pc = pc + `EAG_STEP2;
			end
			eag_pkg::full_absolute: begin
				calc_ea = {opnd1, opnd2};
				calc_pc = pc + `EAG_STEP3;
			end
			eag_pkg::pointer_no_offset: begin
				calc_ea = {`EAG_ZERO_PAGE, index};
				calc_pc = pc + `EAG_STEP1;
			end
			eag_pkg::pointer_byte_offset: begin
				calc_ea = {7'h00, sum_byte};
				calc_pc = pc + `EAG_STEP2;
			end
			eag_pkg::pointer_word_offset: begin
				calc_ea = {opnd1 + {7'h00, sum_word[8]}, sum_word[7:0]};
				calc_pc = pc + `EAG_STEP3;
			end
			eag_pkg::pc_offset_branch: begin
				calc_ea = pc + `EAG_STEP2 + {{8{opnd1[7]}}, opnd1};
				calc_taken = cond;
				calc_pc = cond ? calc_ea : pc + `EAG_STEP2;
			end
			eag_pkg::bit_set_clear: begin
				calc_ea = {`EAG_ZERO_PAGE, opnd1};
				calc_pc = pc + `EAG_STEP2;
			end
			eag_pkg::bit_test_branch: begin
				calc_ea = pc + `EAG_STEP3 + {{8{opnd2[7]}}, opnd2};
				calc_taken = (test_bit == bit_pol);
				calc_pc = calc_taken ? calc_ea : pc + `EAG_STEP3;
			end
			default: calc_pc = pc + `EAG_STEP1;
		endcase
		// jump loads the address into pc
		if (jump && (mode == eag_pkg::full_absolute || mode == eag_pkg::page_zero_absolute ||
			mode == eag_pkg::pointer_no_offset || mode == eag_pkg::pointer_byte_offset ||
			mode == eag_pkg::pointer_word_offset)) begin
			calc_pc = calc_ea;
			calc_taken = 1'b1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state <= eag_pkg::st_idle;
		end else if (I_CE) begin
			state <= next_state;
		end
	end

	// memory request registers
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mem_addr <= `EAG_ADDR_RST;
			mem_we <= 1'b0;
			mem_wdata <= `EAG_BYTE_RST;
		end else if (I_CE) begin
			mem_addr <= next_addr;
			mem_we <= next_we;
			mem_wdata <= next_wdata;
		end
	end

	// decoder fields held so decode may move on
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mode <= eag_pkg::implied_operand;
			bit_sel <= 3'h0;
			bit_pol <= 1'b0;
			cond <= 1'b0;
			jump <= 1'b0;
			index <= `EAG_BYTE_RST;
		end else if (I_CE && state == eag_pkg::st_idle && I_START && !I_PC_LOAD) begin
			mode <= in_mode;
			bit_sel <= I_BIT_SEL;
			bit_pol <= I_BIT_POL;
			cond <= I_COND;
			jump <= I_JUMP;
			index <= I_INDEX;
		end
	end

	// fetched bytes
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			opnd1 <= `EAG_BYTE_RST;
			opnd2 <= `EAG_BYTE_RST;
			data_byte <= `EAG_BYTE_RST;
		end else if (I_CE && I_MEM_ACK) begin
			if (state == eag_pkg::st_fetch1) begin
				opnd1 <= I_MEM_RDATA;
			end
			if (state == eag_pkg::st_fetch2) begin
				opnd2 <= I_MEM_RDATA;
			end
			if (state == eag_pkg::st_read) begin
				data_byte <= I_MEM_RDATA;
			end
		end
	end

	// pc is the single 16 bit fetch pointer
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pc <= `EAG_PC_RST;
		end else if (I_CE) begin
			if (state == eag_pkg::st_finish) begin
				pc <= calc_pc;
			end else if (state == eag_pkg::st_idle && I_PC_LOAD) begin
				pc <= I_PC_VALUE;
			end
		end
	end

	// results stand from the done pulse until the next one
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_EA <= `EAG_ADDR_RST;
			O_TAKEN <= 1'b0;
			O_DONE <= 1'b0;
		end else if (I_CE) begin
			O_DONE <= (state == eag_pkg::st_finish);
			if (state == eag_pkg::st_finish) begin
				O_EA <= calc_ea;
				O_TAKEN <= calc_taken;
			end
		end
	end

	// tested bit to carry, taken or not
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_CARRY <= 1'b0;
			O_CARRY_WE <= 1'b0;
		end else if (I_CE) begin
			O_CARRY_WE <= (state == eag_pkg::st_finish) && (mode == eag_pkg::bit_test_branch);
			if (state == eag_pkg::st_finish && mode == eag_pkg::bit_test_branch) begin
				O_CARRY <= test_bit;
			end
		end
	end

	assign O_PC = pc;
	assign O_MEM_ADDR = mem_addr;
	assign O_MEM_WE = mem_we;
	assign O_MEM_WDATA = mem_wdata;
	// request is a handshake term of the state only
	assign O_MEM_REQ = (state == eag_pkg::st_fetch1) || (state == eag_pkg::st_fetch2) ||
		(state == eag_pkg::st_read) || (state == eag_pkg::st_write);
	assign O_BUSY = (state != eag_pkg::st_idle);

endmodule

// *** sim/eag_mem_model.sv ***
// Purpose: memory seen by eag_top
// Assumes: addresses fold onto 512 bytes
// Notes: random stalls; read data scrambled when idle
`timescale 1ns/1ps
module eag_mem_model (
	// request
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	// answer
	output logic o_ack,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:511];
	integer seed = 32'had3901ea;
	logic ack;
	initial o_ack = 1'b0;
	initial o_rdata = 8'h00;
	// stalls make the block hold its request
	always @(negedge i_clk) begin
		ack = i_req && ($random(seed) & 3) != 0;
		o_ack <= ack;
		o_rdata <= ack ? mem[i_addr[8:0]] : ~o_rdata;
	end
	always @(posedge i_clk) begin
		if (i_req && o_ack && i_we)
			mem[i_addr[8:0]] <= i_wdata;
	end
endmodule

// *** sim/eag_properties.sv ***
// Purpose: timing and address checks on eag_top
// Assumes: I_CE only dropped while idle, so fixed latencies hold
// Notes: bound to every eag_top
`timescale 1ns/1ps
module eag_checker (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// decode
	input wire logic I_CE,
	input wire logic I_START,
	input wire logic [3:0] I_MODE,
	input wire logic [7:0] I_INDEX,
	input wire logic I_PC_LOAD,
	input wire logic [15:0] I_PC_VALUE,
	// memory bus
	input wire logic O_MEM_REQ,
	input wire logic O_MEM_WE,
	input wire logic [15:0] O_MEM_ADDR,
	input wire logic I_MEM_ACK,
	// results
	input wire logic O_BUSY,
	input wire logic O_DONE,
	input wire logic [15:0] O_PC,
	input wire logic [15:0] O_EA,
	input wire logic O_CARRY_WE,
	input wire logic O_CARRY
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);
	sequence s_take(logic [3:0] m);
		I_CE && I_START && !O_BUSY && !I_PC_LOAD && I_MODE == m;
	endsequence
	sequence s_fetch;
		I_CE && I_START && !O_BUSY && !I_PC_LOAD && I_MODE inside {[2:3], [5:9]};
	endsequence
	// no bus cycle, then done
	sequence s_quiet_done;
		!O_MEM_REQ ##1 O_DONE;
	endsequence
	chk_implied_step: assert property (s_take(4'h0) |=>
		s_quiet_done ##0 O_PC == $past(O_PC, 2) + 16'h1) else $error("implied step");
	chk_literal_ea: assert property (s_take(4'h1) |=> s_quiet_done ##0
		O_EA == $past(O_PC, 2) + 16'h1 && O_PC == $past(O_PC, 2) + 16'h2) else $error("literal");
	chk_pointer_ea: assert property (s_take(4'h4) |=>
		s_quiet_done ##0 O_EA == {8'h00, $past(I_INDEX, 2)}) else $error("pointer ea");
	chk_fetch_next: assert property (s_fetch |=> O_MEM_REQ && !O_MEM_WE &&
		O_MEM_ADDR == $past(O_PC) + 16'h1) else $error("first fetch");
	chk_req_hold: assert property (O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ &&
		$stable(O_MEM_ADDR) && $stable(O_MEM_WE)) else $error("request dropped");
	chk_write_page: assert property (O_MEM_REQ && O_MEM_WE |->
		O_MEM_ADDR[15:8] == 8'h00) else $error("write off page zero");
	chk_bsc_write: assert property (s_take(4'h8) |->
		##[3:60] O_MEM_REQ && O_MEM_WE) else $error("no bit write");
	chk_done_bound: assert property (s_fetch |-> ##[3:60] O_DONE)
		else $error("done late");
	chk_carry_done: assert property (O_CARRY_WE |-> O_DONE)
		else $error("carry strobe alone");
	chk_carry_hold: assert property (!O_CARRY_WE |-> $stable(O_CARRY))
		else $error("carry moved");
	chk_pc_load: assert property (I_CE && I_PC_LOAD && !O_BUSY |=>
		O_PC == $past(I_PC_VALUE)) else $error("pc load");
endmodule

bind eag_top eag_checker i_chk (.I_CLK, .I_RST_N, .I_CE, .I_START, .I_MODE, .I_INDEX,
	.I_PC_LOAD, .I_PC_VALUE, .O_MEM_REQ, .O_MEM_WE, .O_MEM_ADDR, .I_MEM_ACK, .O_BUSY,
	.O_DONE, .O_PC, .O_EA, .O_CARRY_WE, .O_CARRY);

// *** sim/test_effective_address_generator.sv ***
// Purpose: self-checking bench for eag_top
// Assumes: decode fields other than the mode come from one random word
// Notes: start is raised with pc load to see it refused
`timescale 1ns/1ps
module test_effective_address_generator;
	logic I_CLK = 0;
	logic I_RST_N = 0;
	logic I_START = 0;
	logic I_CE = 1;
	logic I_PC_LOAD = 0;
	logic [15:0] I_PC_VALUE = 0;
	logic [3:0] mode = 0;
	logic [31:0] d = 0;
	logic [15:0] pc = 0;
	logic O_MEM_REQ, O_MEM_WE, O_BUSY, O_DONE, O_TAKEN, O_CARRY_WE, O_CARRY, I_MEM_ACK;
	logic [15:0] O_MEM_ADDR, O_PC, O_EA;
	logic [7:0] O_MEM_WDATA, I_MEM_RDATA;
	logic [34:0] exp_q [$];
	logic [34:0] e;
	integer seed = 32'had3901ea;
	integer bad_count = 0;
	integer tests_run = 0;

	eag_top i_dut (.I_CLK, .I_RST_N, .I_CE, .I_START, .I_MODE(mode),
		.I_BIT_SEL(d[6:4]), .I_BIT_POL(d[7]), .I_COND(d[8]), .I_JUMP(d[9]),
		.I_INDEX(d[17:10]), .I_PC_LOAD, .I_PC_VALUE, .O_MEM_REQ, .O_MEM_WE, .O_MEM_ADDR,
		.O_MEM_WDATA, .I_MEM_ACK, .I_MEM_RDATA, .O_BUSY, .O_DONE, .O_TAKEN, .O_PC, .O_EA,
		.O_CARRY_WE, .O_CARRY);
	eag_mem_model i_mem (.i_clk(I_CLK), .i_req(O_MEM_REQ), .i_we(O_MEM_WE),
		.i_addr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA), .o_ack(I_MEM_ACK), .o_rdata(I_MEM_RDATA));

	initial begin
		forever #2 I_CLK = ~I_CLK;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, seen, want);
		end
	endtask

	task automatic stop_test();
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic run(input logic [3:0] m);
		logic [15:0] p, ea, np;
		logic [7:0] b1, b2, v, mask;
		logic t;
		integer k;
		d = $random(seed);
		p = d[31] ? 16'($random(seed)) : pc;
		b1 = 8'($random(seed));
		b2 = 8'($random(seed));
		i_mem.mem[9'(p + 16'h1)] = b1;
		i_mem.mem[9'(p + 16'h2)] = b2;
		v = i_mem.mem[{1'b0, b1}];
		mask = 8'h01 << d[6:4];
		case (m)
			4'h1: ea = p + 16'h1;
			4'h2, 4'h8: ea = {8'h00, b1};
			4'h3: ea = {b1, b2};
			4'h4: ea = {8'h00, d[17:10]};
			4'h5: ea = {8'h00, b1} + d[17:10];
			4'h6: ea = {b1, b2} + d[17:10];
			4'h7: ea = p + 16'h2 + {{8{b1[7]}}, b1};
			4'h9: ea = p + 16'h3 + {{8{b2[7]}}, b2};
			default: ea = 16'h0000;
		endcase
		np = p + (m inside {4'h3, 4'h6, 4'h9} ? 16'h3 :
			m inside {[4'h1:4'h2], 4'h5, 4'h7, 4'h8} ? 16'h2 : 16'h1);
		t = m == 4'h7 ? d[8] : m == 4'h9 ? v[d[6:4]] == d[7] : m inside {[4'h2:4'h6]} && d[9];
		np = t ? ea : np;
		exp_q.push_back({np, ea, t, m == 4'h9, v[d[6:4]]});
		pc = np;
		mode = m;
		I_PC_VALUE = p;
		I_PC_LOAD = d[31];
		I_START = 1;
		@(negedge I_CLK);
		I_PC_LOAD = 0;
		@(negedge I_CLK);
		I_START = 0;
		for (k = 0; k < 99 && O_DONE !== 1'b1; k++)
			@(negedge I_CLK);
		chk(O_DONE, 1'b1);
		if (m == 4'h8)
			chk(i_mem.mem[{1'b0, b1}], d[7] ? v | mask : v & ~mask);
		if (bad_count > 0)
			stop_test();
	endtask

	// oldest note pairs with each finished instruction
	always @(negedge I_CLK) begin
		if (O_DONE === 1'b1) begin
			e = exp_q.pop_front();
			chk(O_PC, e[34:19]);
			chk(O_BUSY, 1'b0);
			chk(O_EA, e[18:3]);
			chk(O_TAKEN, e[2]);
			chk(O_CARRY_WE, e[1]);
			chk(e[1] ? O_CARRY : 1'b0, e[0] & e[1]);
		end
	end

	initial begin
		for (int a = 0; a < 512; a++)
			i_mem.mem[a] = 8'($random(seed));
		repeat (8) @(negedge I_CLK);
		I_RST_N = 1;
		for (int n = 0; n < 240; n++)
			run(n < 16 ? 4'(n) : 4'($random(seed)));
		// let the last done pulse drop before freezing
		@(negedge I_CLK);
		I_CE = 0;
		I_START = 1;
		I_PC_LOAD = 1;
		I_PC_VALUE = ~pc;
		mode = 4'h2;
		repeat (3) @(negedge I_CLK);
		chk(O_PC, pc);
		chk(O_BUSY, 1'b0);
		chk(O_DONE, 1'b0);
		I_CE = 1;
		I_START = 0;
		I_PC_LOAD = 0;
		repeat (2) @(negedge I_CLK);
		chk(O_PC, pc);
		chk(O_BUSY, 1'b0);
		stop_test();
	end
endmodule
